// >>> logic/fsq_flash_cycle.sv
`timescale 1ns/10ps
module fsq_flash_cycle
  import fsq_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              req,
  input  wire logic              wr,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [DATA_W-1:0] fdq_i,
  output logic                   done,
  output logic      [DATA_W-1:0] rdata,
  output logic      [ADDR_W-1:0] fa,
  output logic      [DATA_W-1:0] fdq_o,
  output logic                   fdq_oe,
  output logic                   cs_n,
  output logic                   we_n,
  output logic                   oe_n
);
  typedef enum logic [2:0] {
    C_IDLE = 3'b001, C_ACT = 3'b010, C_REC = 3'b100
  } fsq_cyc_t;

  fsq_cyc_t          st_r, st_nxt;
  logic [3:0]        cnt_r, cnt_nxt;
  logic              wr_r, wr_nxt;
  logic              done_nxt, fdq_oe_nxt, cs_n_nxt, we_n_nxt, oe_n_nxt;
  logic [DATA_W-1:0] rdata_nxt, fdq_o_nxt;
  logic [ADDR_W-1:0] fa_nxt;

  always_comb begin
    st_nxt     = st_r;
    cnt_nxt    = cnt_r;
    wr_nxt     = wr_r;
    done_nxt   = 1'b0;
    rdata_nxt  = rdata;
    fa_nxt     = fa;
    fdq_o_nxt  = fdq_o;
    fdq_oe_nxt = fdq_oe;
    cs_n_nxt   = cs_n;
    we_n_nxt   = we_n;
    oe_n_nxt   = oe_n;
    unique case (st_r)
      C_IDLE: if (req) begin
        wr_nxt     = wr;
        fa_nxt     = addr;
        fdq_o_nxt  = wdata;
        fdq_oe_nxt = wr;
        cs_n_nxt   = 1'b0;
        we_n_nxt   = ~wr;
        oe_n_nxt   = wr;
        cnt_nxt    = wr ? 4'(WE_CYC - 1) : 4'(ACC_CYC - 1);
        st_nxt     = C_ACT;
      end
      C_ACT: if (cnt_r == 4'h0) begin
        // Data is held through recovery so it outlasts the write edge
        if (!wr_r) rdata_nxt = fdq_i;
        cs_n_nxt = 1'b1;
        we_n_nxt = 1'b1;
        oe_n_nxt = 1'b1;
        cnt_nxt  = 4'(REC_CYC - 1);
        st_nxt   = C_REC;
      end else begin
        cnt_nxt = cnt_r - 4'h1;
      end
      C_REC: if (cnt_r == 4'h0) begin
        fdq_oe_nxt = 1'b0;
        done_nxt   = 1'b1;
        st_nxt     = C_IDLE;
      end else begin
        cnt_nxt = cnt_r - 4'h1;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r   <= C_IDLE;
      cnt_r  <= 4'h0;
      wr_r   <= 1'b0;
      done   <= 1'b0;
      rdata  <= '0;
      fa     <= '0;
      fdq_o  <= '0;
      fdq_oe <= 1'b0;
      cs_n   <= 1'b1;
      we_n   <= 1'b1;
      oe_n   <= 1'b1;
    end else begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      wr_r   <= wr_nxt;
      done   <= done_nxt;
      rdata  <= rdata_nxt;
      fa     <= fa_nxt;
      fdq_o  <= fdq_o_nxt;
      fdq_oe <= fdq_oe_nxt;
      cs_n   <= cs_n_nxt;
      we_n   <= we_n_nxt;
      oe_n   <= oe_n_nxt;
    end
  end
endmodule : fsq_flash_cycle

// >>> logic/fsq_sequencer.sv
`timescale 1ns/10ps
module fsq_sequencer
  import fsq_pkg::*;
(
  input  wire logic                       CLK,
  input  wire logic                       RST,
  input  wire logic [4:0]                 AVS_ADDRESS,
  input  wire logic                       AVS_READ,
  input  wire logic                       AVS_WRITE,
  input  wire logic [31:0]                AVS_WRITEDATA,
  input  wire logic [3:0]                 AVS_BYTEENABLE,
  output logic      [31:0]                AVS_READDATA,
  output logic                            AVS_WAITREQUEST,
  output logic      [fsq_pkg::ADDR_W-1:0] FLASH_ADDR,
  input  wire logic [fsq_pkg::DATA_W-1:0] FLASH_DQ_IN,
  output logic      [fsq_pkg::DATA_W-1:0] FLASH_DQ_OUT,
  output logic                            FLASH_DQ_OE,
  output logic                            CHIP_SELECT_N,
  output logic                            FLASH_WE_N,
  output logic                            FLASH_OE_N,
  output logic                            RESET_POWERDOWN_N
);
  import fsq_pkg::*;

  // ------------------------------------------------------------------
  // Byte-lane merge
  // ------------------------------------------------------------------
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[8*i +: 8] = new_v[8*i +: 8];
    end
    return r;
  endfunction : lane_merge

  typedef enum logic [10:0] {
    Q_IDLE     = 11'b00000000001, Q_WAIT     = 11'b00000000010,
    Q_XSR      = 11'b00000000100, Q_XSR_CHK  = 11'b00000001000,
    Q_DATA     = 11'b00000010000, Q_CONFIRM  = 11'b00000100000,
    Q_POLL_CMD = 11'b00001000000, Q_POLL_RD  = 11'b00010000000,
    Q_POLL_CHK = 11'b00100000000, Q_END      = 11'b01000000000,
    Q_ARRAY    = 11'b10000000000
  } fsq_state_t;

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  logic              wait_r, wait_nxt;
  logic [31:0]       rdat_r, rdat_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [DATA_W-1:0] wdat_r, wdat_nxt;
  logic [CNT_W-1:0]  count_r, count_nxt;
  logic [BUF_AW-1:0] bwp_r, bwp_nxt;
  logic              pd_r, pd_nxt;
  logic              go_r, go_nxt;
  fsq_op_t           req_op_r, req_op_nxt;
  logic [DATA_W-1:0] buf_mem [BUF_DEPTH];
  logic              buf_we;

  fsq_state_t        st_r, st_nxt, ret_r, ret_nxt;
  fsq_op_t           op_r, op_nxt;
  fsq_res_t          res_r, res_nxt, res_dec;
  logic              busy_r, busy_nxt;
  logic              nclr_r, nclr_nxt;
  logic [7:0]        sr_r, sr_nxt, xsr_r, xsr_nxt;
  logic [CNT_W-1:0]  idx_r, idx_nxt;
  logic              iss, iss_wr;
  logic [ADDR_W-1:0] iss_addr;
  logic [DATA_W-1:0] iss_data;
  logic              cyc_done;
  logic [DATA_W-1:0] cyc_rdata;

  wire logic [2:0] widx = AVS_ADDRESS[4:2];
  wire logic       acc  = (AVS_READ | AVS_WRITE) & wait_r;

  // ------------------------------------------------------------------
  // Avalon slave: one wait cycle, then a one-cycle answer
  // ------------------------------------------------------------------
  always_comb begin
    wait_nxt   = 1'b1;
    rdat_nxt   = rdat_r;
    addr_nxt   = addr_r;
    wdat_nxt   = wdat_r;
    count_nxt  = count_r;
    bwp_nxt    = bwp_r;
    pd_nxt     = pd_r;
    go_nxt     = 1'b0;
    req_op_nxt = req_op_r;
    buf_we     = 1'b0;
    if (acc) begin
      wait_nxt = 1'b0;
      rdat_nxt = 32'h0;
      if (AVS_READ) begin
        unique case (widx)
          REG_CTRL:   rdat_nxt[CTRL_PD_BIT] = pd_r;
          REG_ADDR:   rdat_nxt[ADDR_W-1:0]  = addr_r;
          REG_WDATA:  rdat_nxt[DATA_W-1:0]  = wdat_r;
          REG_COUNT:  rdat_nxt[CNT_W-1:0]   = count_r;
          REG_STATUS: begin
            rdat_nxt[ST_BUSY]                = busy_r;
            rdat_nxt[ST_NEED_CLEAR]          = nclr_r;
            rdat_nxt[ST_PD]                  = pd_r;
            rdat_nxt[ST_RES_LSB +: 3]        = res_r;
            rdat_nxt[ST_SR_LSB +: 8]         = sr_r;
            rdat_nxt[ST_XSR_LSB + XBIT_AVAIL] = xsr_r[XBIT_AVAIL];
          end
          default:    rdat_nxt = 32'h0;
        endcase
      end else begin
        unique case (widx)
          REG_CTRL: begin
            if (AVS_BYTEENABLE[1]) pd_nxt = AVS_WRITEDATA[CTRL_PD_BIT];
            if (AVS_BYTEENABLE[0]) begin
              req_op_nxt = fsq_op_t'(AVS_WRITEDATA[2:0]);
              go_nxt     = 1'b1;
            end
          end
          REG_ADDR: begin
            addr_nxt = ADDR_W'(lane_merge(32'(addr_r), AVS_WRITEDATA,
                                          AVS_BYTEENABLE));
          end
          REG_WDATA: begin
            wdat_nxt = DATA_W'(lane_merge(32'(wdat_r), AVS_WRITEDATA,
                                          AVS_BYTEENABLE));
          end
          REG_COUNT: begin
            // Loading a count also rewinds the buffer fill pointer
            if (AVS_BYTEENABLE[0]) count_nxt = AVS_WRITEDATA[CNT_W-1:0];
            bwp_nxt = '0;
          end
          REG_BUF: begin
            buf_we  = 1'b1;
            bwp_nxt = bwp_r + 1'b1;
          end
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (buf_we) buf_mem[bwp_r] <= AVS_WRITEDATA[DATA_W-1:0];
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      wait_r   <= 1'b1;
      rdat_r   <= 32'h0;
      addr_r   <= '0;
      wdat_r   <= '0;
      count_r  <= '0;
      bwp_r    <= '0;
      pd_r     <= 1'b0;
      go_r     <= 1'b0;
      req_op_r <= OP_NONE;
    end else begin
      wait_r   <= wait_nxt;
      rdat_r   <= rdat_nxt;
      addr_r   <= addr_nxt;
      wdat_r   <= wdat_nxt;
      count_r  <= count_nxt;
      bwp_r    <= bwp_nxt;
      pd_r     <= pd_nxt;
      go_r     <= go_nxt;
      req_op_r <= req_op_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Command sequencer
  // ------------------------------------------------------------------
  fsq_status_check u_check (
    .op  (op_r),
    .sr  (cyc_rdata[7:0]),
    .res (res_dec)
  );

  always_comb begin
    st_nxt   = st_r;
    ret_nxt  = ret_r;
    op_nxt   = op_r;
    res_nxt  = res_r;
    busy_nxt = busy_r;
    nclr_nxt = nclr_r;
    sr_nxt   = sr_r;
    xsr_nxt  = xsr_r;
    idx_nxt  = idx_r;
    iss      = 1'b0;
    iss_wr   = 1'b1;
    iss_addr = addr_r;
    iss_data = DATA_W'(CMD_READ_STATUS);
    unique case (st_r)
      Q_IDLE: if (go_r && req_op_r != OP_NONE) begin
        op_nxt = req_op_r;
        // A sequence error must be cleared before new work other than a read-array is taken
        if (pd_r || count_r == '0 && req_op_r == OP_BUF_WRITE ||
            nclr_r && req_op_r != OP_CLEAR_STATUS &&
            req_op_r != OP_READ_ARRAY) begin
          res_nxt = RES_REFUSED;
        end else begin
          busy_nxt = 1'b1;
          res_nxt  = RES_OK;
          iss      = 1'b1;
          idx_nxt  = '0;
          unique case (req_op_r)
            OP_BANK_ERASE: begin
              iss_data = DATA_W'(CMD_BANK_ERASE);
              ret_nxt  = Q_CONFIRM;
            end
            OP_WORD_WRITE: begin
              iss_data = DATA_W'(CMD_WORD_WRITE);
              ret_nxt  = Q_DATA;
            end
            OP_BUF_WRITE: begin
              iss_data = DATA_W'(CMD_BUF_WRITE);
              ret_nxt  = Q_XSR;
            end
            OP_SET_LOCK, OP_CLEAR_LOCKS: begin
              iss_data = DATA_W'(CMD_LOCK_SETUP);
              ret_nxt  = Q_CONFIRM;
            end
            OP_CLEAR_STATUS: begin
              iss_data = DATA_W'(CMD_CLEAR_STATUS);
              sr_nxt   = 8'h00;
              nclr_nxt = 1'b0;
              ret_nxt  = Q_ARRAY;
            end
            default: begin
              iss_data = DATA_W'(CMD_READ_ARRAY);
              ret_nxt  = Q_END;
            end
          endcase
        end
      end
      Q_WAIT: if (cyc_done) st_nxt = ret_r;
      Q_XSR: begin
        iss     = 1'b1;
        iss_wr  = 1'b0;
        ret_nxt = Q_XSR_CHK;
      end
      Q_XSR_CHK: begin
        iss     = 1'b1;
        xsr_nxt = cyc_rdata[7:0];
        // Reserved extended bits are ignored
        if (cyc_rdata[XBIT_AVAIL]) begin
          iss_data = DATA_W'(8'(count_r - 1'b1));
          ret_nxt  = Q_DATA;
        end else begin
          iss_data = DATA_W'(CMD_BUF_WRITE);
          ret_nxt  = Q_XSR;
        end
      end
      Q_DATA: begin
        iss = 1'b1;
        if (op_r == OP_WORD_WRITE) begin
          iss_data = wdat_r;
          ret_nxt  = Q_POLL_CMD;
        end else begin
          // Block boundary is the device's to police; we report its abort
          iss_addr = addr_r + ADDR_W'(idx_r);
          iss_data = buf_mem[idx_r[BUF_AW-1:0]];
          idx_nxt  = idx_r + 1'b1;
          ret_nxt  = (idx_r == count_r - 1'b1) ? Q_CONFIRM : Q_DATA;
        end
      end
      Q_CONFIRM: begin
        iss      = 1'b1;
        iss_data = (op_r == OP_SET_LOCK) ? DATA_W'(CMD_LOCK_SET)
                                         : DATA_W'(CMD_CONFIRM);
        ret_nxt  = Q_POLL_CMD;
      end
      Q_POLL_CMD: begin
        iss     = 1'b1;
        ret_nxt = Q_POLL_RD;
      end
      Q_POLL_RD: begin
        iss     = 1'b1;
        iss_wr  = 1'b0;
        ret_nxt = Q_POLL_CHK;
      end
      Q_POLL_CHK: begin
        iss = 1'b1;
        if (cyc_rdata[BIT_READY]) begin
          // Errors are only meaningful once the engine is idle
          sr_nxt   = cyc_rdata[7:0];
          res_nxt  = res_dec;
          nclr_nxt = nclr_r | (res_dec == RES_SEQUENCE);
          iss_data = DATA_W'(CMD_READ_ARRAY);
          ret_nxt  = Q_END;
        end else begin
          iss_wr  = 1'b0;
          ret_nxt = Q_POLL_CHK;
        end
      end
      Q_ARRAY: begin
        iss      = 1'b1;
        iss_data = DATA_W'(CMD_READ_ARRAY);
        ret_nxt  = Q_END;
      end
      Q_END: begin
        busy_nxt = 1'b0;
        st_nxt   = Q_IDLE;
      end
    endcase
    if (iss) st_nxt = Q_WAIT;
    // Power-down wipes the device status, so drop our copy too
    if (pd_r) begin
      sr_nxt   = 8'h00;
      xsr_nxt  = 8'h00;
      nclr_nxt = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      st_r   <= Q_IDLE;
      ret_r  <= Q_IDLE;
      op_r   <= OP_NONE;
      res_r  <= RES_OK;
      busy_r <= 1'b0;
      nclr_r <= 1'b0;
      sr_r   <= 8'h00;
      xsr_r  <= 8'h00;
      idx_r  <= '0;
      RESET_POWERDOWN_N <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      ret_r  <= ret_nxt;
      op_r   <= op_nxt;
      res_r  <= res_nxt;
      busy_r <= busy_nxt;
      nclr_r <= nclr_nxt;
      sr_r   <= sr_nxt;
      xsr_r  <= xsr_nxt;
      idx_r  <= idx_nxt;
      RESET_POWERDOWN_N <= ~pd_r;
    end
  end

  assign AVS_READDATA    = rdat_r;
  assign AVS_WAITREQUEST = wait_r;

  fsq_flash_cycle u_cycle (
    .clk    (CLK),
    .rst    (RST),
    .req    (iss),
    .wr     (iss_wr),
    .addr   (iss_addr),
    .wdata  (iss_data),
    .fdq_i  (FLASH_DQ_IN),
    .done   (cyc_done),
    .rdata  (cyc_rdata),
    .fa     (FLASH_ADDR),
    .fdq_o  (FLASH_DQ_OUT),
    .fdq_oe (FLASH_DQ_OE),
    .cs_n   (CHIP_SELECT_N),
    .we_n   (FLASH_WE_N),
    .oe_n   (FLASH_OE_N)
  );
endmodule : fsq_sequencer

// >>> logic/fsq_status_check.sv
`timescale 1ns/10ps
module fsq_status_check
  import fsq_pkg::*;
(
  input  fsq_pkg::fsq_op_t  op,
  input  wire logic [7:0]   sr,
  output fsq_pkg::fsq_res_t res
);
  // Supply first, then protection, then sequence, then op failure
  always_comb begin
    res = RES_OK;
    if (sr[BIT_SUPPLY]) begin
      res = RES_SUPPLY;
    end else if (sr[BIT_PROTECT]) begin
      res = RES_PROTECT;
    end else if (sr[BIT_PROG_FAIL] && sr[BIT_ERASE_FAIL]) begin
      res = RES_SEQUENCE;
    end else if ((op == OP_BANK_ERASE || op == OP_CLEAR_LOCKS) &&
                 sr[BIT_ERASE_FAIL]) begin
      res = RES_OP_FAIL;
    end else if ((op == OP_WORD_WRITE || op == OP_BUF_WRITE ||
                  op == OP_SET_LOCK) && sr[BIT_PROG_FAIL]) begin
      res = RES_OP_FAIL;
    end
  end
endmodule : fsq_status_check

// >>> shared/fsq_pkg.sv
package fsq_pkg;
  // ------------------------------------------------------------------
  // Widths and timing
  // ------------------------------------------------------------------
  localparam int ADDR_W    = 24;
  localparam int DATA_W    = 16;
  localparam int BUF_DEPTH = 32;
  localparam int BUF_AW    = 5;
  localparam int CNT_W     = 6;
  localparam int CLK_MHZ   = 40;
  localparam int T_WE_NS   = 50;
  localparam int T_ACC_NS  = 70;
  localparam int T_REC_NS  = 25;
  // Least times, rounded up to whole clocks
  localparam int WE_CYC    = (T_WE_NS * CLK_MHZ + 999) / 1000;
  localparam int ACC_CYC   = (T_ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int REC_CYC   = (T_REC_NS * CLK_MHZ + 999) / 1000;

  // ------------------------------------------------------------------
  // Device command codes and status bits
  // ------------------------------------------------------------------
  localparam logic [7:0] CMD_READ_ARRAY   = 8'hff;
  localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_BANK_ERASE   = 8'h30;
  localparam logic [7:0] CMD_CONFIRM      = 8'hd0;
  localparam logic [7:0] CMD_WORD_WRITE   = 8'h40;
  localparam logic [7:0] CMD_BUF_WRITE    = 8'he8;
  localparam logic [7:0] CMD_LOCK_SETUP   = 8'h60;
  localparam logic [7:0] CMD_LOCK_SET     = 8'h01;
  localparam int BIT_READY      = 7;
  localparam int BIT_ERASE_FAIL = 5;
  localparam int BIT_PROG_FAIL  = 4;
  localparam int BIT_SUPPLY     = 3;
  localparam int BIT_PROTECT    = 1;
  localparam int XBIT_AVAIL     = 7;

  // ------------------------------------------------------------------
  // Register map (word index, byte address = 4 * index)
  // ------------------------------------------------------------------
  localparam logic [2:0] REG_CTRL   = 3'h0;
  localparam logic [2:0] REG_ADDR   = 3'h1;
  localparam logic [2:0] REG_WDATA  = 3'h2;
  localparam logic [2:0] REG_COUNT  = 3'h3;
  localparam logic [2:0] REG_BUF    = 3'h4;
  localparam logic [2:0] REG_STATUS = 3'h5;
  localparam int CTRL_PD_BIT   = 8;
  localparam int ST_BUSY       = 0;
  localparam int ST_NEED_CLEAR = 1;
  localparam int ST_PD         = 2;
  localparam int ST_RES_LSB    = 4;
  localparam int ST_SR_LSB     = 8;
  localparam int ST_XSR_LSB    = 16;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0, OP_BANK_ERASE = 3'h1, OP_WORD_WRITE = 3'h2,
    OP_BUF_WRITE = 3'h3, OP_SET_LOCK = 3'h4, OP_CLEAR_LOCKS = 3'h5,
    OP_CLEAR_STATUS = 3'h6, OP_READ_ARRAY = 3'h7
  } fsq_op_t;

  typedef enum logic [2:0] {
    RES_OK = 3'h0, RES_SUPPLY = 3'h1, RES_PROTECT = 3'h2,
    RES_SEQUENCE = 3'h3, RES_OP_FAIL = 3'h4, RES_REFUSED = 3'h5
  } fsq_res_t;
endpackage : fsq_pkg

// >>> test/fsq_flash_model.sv
`timescale 1ns/10ps
module fsq_flash_model #(
  parameter int BLK_W = 4
) (
  input  wire logic [23:0] addr,
  input  wire logic [15:0] dq_h,
  input  wire logic        cs_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic        rp_n,
  input  wire logic [7:0]  err_bits,
  input  wire logic [3:0]  slow,
  output logic      [15:0] dq_d,
  output logic      [7:0]  sr,
  output logic      [15:0] last_data,
  output logic             arr_mode
);
  logic [1:0]  mode;
  logic [2:0]  st;
  logic [7:0]  cnt;
  logic [7:0]  n;
  logic [3:0]  wt;
  logic [23:0] a0;
  wire         wr_act = !cs_n && !we_n;
  wire         rd_act = !cs_n && !oe_n;
  wire  [7:0]  d = dq_h[7:0];
  wire  [15:0] rv = mode == 2'h0 ? addr[15:0] ^ 16'h5a5a
    : {8'h00, wt == 4'h0, mode == 2'h1 ? sr[6:0] : 7'h55};
  // Released bus shows the inverse, never a stale value
  assign dq_d = rd_act ? rv : ~rv;
  assign arr_mode = mode == 2'h0;
  task fin;
    mode = 2'h1;
    wt = slow;
    sr = sr | err_bits;
    st = 3'h0;
  endtask : fin
  task bad;
    sr[5:4] = 2'b11;
    mode = 2'h1;
    st = 3'h0;
  endtask : bad
  always @(negedge rd_act) if (wt != 4'h0) wt = wt - 4'h1;
  always @(negedge wr_act or negedge rp_n) begin
    if (!rp_n) begin
      sr = 8'h00;
      mode = 2'h0;
      st = 3'h0;
      wt = 4'h0;
    end else case (st)
      3'h0: begin
        a0 = addr;
        case (d)
          8'hff: mode = 2'h0;
          8'h70: mode = 2'h1;
          8'h50: sr = 8'h00;
          8'h40, 8'h10: st = 3'h1;
          8'h30: st = 3'h2;
          8'h60: st = 3'h3;
          8'he8: begin
            st = 3'h4;
            mode = 2'h2;
            wt = slow;
          end
          default: ;
        endcase
      end
      3'h1: if (addr != a0) bad(); else begin
        last_data = dq_h;
        fin();
      end
      3'h2, 3'h6: if (d == 8'hd0) fin(); else bad();
      3'h3: if (d == 8'hd0 || d == 8'h01 && addr == a0) fin();
        else bad();
      3'h4: if (d == 8'he8) st = 3'h4; else if (wt != 4'h0) bad(); else begin
        cnt = d;
        n = 8'h00;
        st = 3'h5;
      end
      default: if (addr[23:BLK_W] != a0[23:BLK_W] || addr != a0 + 24'(n))
        bad(); else begin
        last_data = dq_h;
        n = n + 8'h01;
        if (n > cnt) st = 3'h6;
      end
    endcase
  end
endmodule : fsq_flash_model

// >>> test/fsq_properties.sv
`timescale 1ns/10ps
module fsq_properties (
  input wire logic                       CLK,
  input wire logic                       RST,
  input wire logic                       AVS_READ,
  input wire logic                       AVS_WRITE,
  input wire logic                       AVS_WAITREQUEST,
  input wire logic [fsq_pkg::DATA_W-1:0] FLASH_DQ_OUT,
  input wire logic                       FLASH_DQ_OE,
  input wire logic                       CHIP_SELECT_N,
  input wire logic                       FLASH_WE_N,
  input wire logic                       FLASH_OE_N,
  input wire logic                       RESET_POWERDOWN_N
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  sequence s_we_pulse;
    !FLASH_WE_N [*2] ##1 FLASH_WE_N;
  endsequence
  sequence s_oe_pulse;
    !FLASH_OE_N [*3] ##1 FLASH_OE_N;
  endsequence
  a_answer_next: assert property (
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("late answer");
  a_wait_pulse: assert property (
    !AVS_WAITREQUEST |=> AVS_WAITREQUEST) else $error("long answer");
  a_we_width: assert property (
    $fell(FLASH_WE_N) |-> s_we_pulse) else $error("write strobe width");
  a_we_drive: assert property (
    !FLASH_WE_N |-> !CHIP_SELECT_N && FLASH_DQ_OE && FLASH_OE_N)
    else $error("write strobe alone");
  a_dq_recover: assert property (
    $rose(FLASH_WE_N) |-> FLASH_DQ_OE && $stable(FLASH_DQ_OUT)
    && CHIP_SELECT_N) else $error("data not held");
  a_oe_width: assert property (
    $fell(FLASH_OE_N) |-> s_oe_pulse) else $error("read strobe width");
  a_oe_float: assert property (
    !FLASH_OE_N |-> !FLASH_DQ_OE && !CHIP_SELECT_N)
    else $error("bus fight");
  a_reset_pins: assert property (disable iff (1'b0)
    RST |=> !RESET_POWERDOWN_N && FLASH_WE_N && CHIP_SELECT_N)
    else $error("pins in reset");
endmodule : fsq_properties

bind fsq_sequencer fsq_properties fsq_properties_inst (
  .CLK(CLK), .RST(RST), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .FLASH_DQ_OUT(FLASH_DQ_OUT),
  .FLASH_DQ_OE(FLASH_DQ_OE), .CHIP_SELECT_N(CHIP_SELECT_N),
  .FLASH_WE_N(FLASH_WE_N), .FLASH_OE_N(FLASH_OE_N),
  .RESET_POWERDOWN_N(RESET_POWERDOWN_N));

// >>> test/testbench.sv
`timescale 1ns/10ps
module testbench;
  import fsq_pkg::*;
  logic        clk, rst, rd, wr, oe, csn, wen, oen, rpn, wrq, am;
  logic [4:0]  adr;
  logic [31:0] wd, rdat, s;
  logic [23:0] fa;
  logic [15:0] dqo, dqd, ld;
  logic [7:0]  err, msr;
  logic [3:0]  slow;
  int          mismatches = 0;
  int          num_checks = 0;
  // Table rows: operation, injected status bits, expected result
  logic [13:0] tab [8] = '{
    {3'h1, 8'h28, 3'h1}, {3'h1, 8'h20, 3'h4}, {3'h2, 8'h10, 3'h4},
    {3'h4, 8'h10, 3'h4}, {3'h5, 8'h20, 3'h4}, {3'h2, 8'h02, 3'h2},
    {3'h4, 8'h32, 3'h2}, {3'h1, 8'h30, 3'h3}};
  wire [15:0] dq = oe ? dqo : dqd;
  fsq_sequencer fsq_sequencer_inst (.CLK(clk), .RST(rst),
    .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd),
    .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wrq),
    .FLASH_ADDR(fa), .FLASH_DQ_IN(dq), .FLASH_DQ_OUT(dqo),
    .FLASH_DQ_OE(oe), .CHIP_SELECT_N(csn), .FLASH_WE_N(wen),
    .FLASH_OE_N(oen), .RESET_POWERDOWN_N(rpn));
  fsq_flash_model #(.BLK_W(4)) fsq_flash_model_inst (.addr(fa), .dq_h(dq),
    .cs_n(csn), .we_n(wen), .oe_n(oen), .rp_n(rpn), .err_bits(err),
    .slow(slow), .dq_d(dqd), .sr(msr), .last_data(ld), .arr_mode(am));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task conclude;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  task wait_ack;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wrq !== 1'b0 && n < 20);
    if (wrq !== 1'b0) begin
      mismatches++;
      conclude();
    end
  endtask : wait_ack
  task wr_reg(input logic [2:0] i, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    adr <= {i, 2'b00};
    wd <= d;
    wait_ack();
    wr <= 1'b0;
  endtask : wr_reg
  task rd_reg(input logic [2:0] i, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    adr <= {i, 2'b00};
    wait_ack();
    d = rdat;
    rd <= 1'b0;
  endtask : rd_reg
  task run_op(input logic pd, input fsq_op_t op, input fsq_res_t res);
    int n;
    wr_reg(REG_CTRL, {23'h0, pd, 5'h0, op});
    repeat (3) @(posedge clk);
    n = 0;
    do begin
      rd_reg(REG_STATUS, s);
      n++;
    end while (s[ST_BUSY] !== 1'b0 && n < 500);
    if (s[ST_BUSY] !== 1'b0) begin
      mismatches++;
      conclude();
    end
    check(32'(s[ST_RES_LSB +: 3]), 32'(res));
  endtask : run_op
  initial begin
    {rst, rd, wr, adr, wd, err, slow} = {3'b100, 49'h0};
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd_reg(REG_STATUS, s);
    check(s, 32'h0);
    rd_reg(3'h6, s);
    check(s, 32'h0);
    slow = 4'h3;
    wr_reg(REG_ADDR, 32'h1000);
    run_op(1'b0, OP_BANK_ERASE, RES_OK);
    check(s, 32'h8000);
    check(32'(am), 32'h1);
    slow = 4'h0;
    for (int i = 0; i < 8; i++) begin
      err = tab[i][10:3];
      run_op(1'b0, fsq_op_t'(tab[i][13:11]), fsq_res_t'(tab[i][2:0])
      );
      err = 8'h00;
      run_op(1'b0, fsq_op_t'(tab[i][13:11]), tab[i][2:0] == 3'h3 ?
        RES_REFUSED : fsq_res_t'(tab[i][2:0]));
      run_op(1'b0, OP_CLEAR_STATUS, RES_OK);
    end
    wr_reg(REG_WDATA, 32'hbeef);
    run_op(1'b0, OP_WORD_WRITE, RES_OK);
    check(32'(ld), 32'hbeef);
    slow = 4'h3;
    for (int k = 0; k < 2; k++) begin
      // Second pass runs off the end of its block on the third item
      wr_reg(REG_ADDR, k ? 32'h2e : 32'h20);
      wr_reg(REG_COUNT, k ? 32'h4 : 32'h3);
      for (int j = 1; j <= 4 - k; j++) wr_reg(REG_BUF, 32'h1230 + j);
      run_op(1'b0, OP_BUF_WRITE, k ? RES_SEQUENCE : RES_OK
      );
      check(32'(s[ST_XSR_LSB + XBIT_AVAIL]), 32'h1);
    end
    // Last item taken is the one just before the block edge
    check(32'(ld), 32'h1232);
    run_op(1'b0, OP_WORD_WRITE, RES_REFUSED);
    run_op(1'b0, OP_READ_ARRAY, RES_OK);
    wr_reg(REG_CTRL, 32'h100);
    repeat (4) @(posedge clk);
    check({rpn, msr}, 9'h0);
    run_op(1'b1, OP_CLEAR_STATUS, RES_REFUSED);
    run_op(1'b0, OP_CLEAR_STATUS, RES_OK);
    check({rpn, am}, 2'b11);
    wr_reg(REG_COUNT, 32'h0);
    run_op(1'b0, OP_BUF_WRITE, RES_REFUSED);
    conclude();
  end
  initial begin
    repeat (90000) @(posedge clk);
    mismatches++;
    conclude();
  end
endmodule : testbench
